// ===== src/fsm_pkg.sv
// constants and types for the clock fail monitor
package fsm_pkg;
  // ==========================================
  // register map
  localparam logic [3:0] FSM_OFS_OSC_CONTROL = 4'h0;
  localparam logic [3:0] FSM_OFS_OSC_STATUS = 4'h1;
  localparam logic [3:0] FSM_OFS_FLAG2 = 4'h2;
  localparam logic [3:0] FSM_OFS_ENABLE2 = 4'h3;
  // ==========================================
  // field positions
  localparam int FSM_CSS_LSB = 0;
  localparam int FSM_IFS_LSB = 3;
  localparam int FSM_FLAG_BIT = 7;
  localparam int FSM_IRQEN_BIT = 7;
  localparam int FSM_ST_SUT_DONE = 0;
  localparam int FSM_ST_ON_EXT = 1;
  localparam int FSM_ST_FAILSAFE = 2;
  localparam int FSM_ST_ON_INT = 3;
  localparam int FSM_ST_SAMPLE = 4;
  // ==========================================
  // reset values
  localparam logic [3:0] FSM_IFS_RESET = 4'h7;
  localparam logic [1:0] FSM_CSS_RESET = 2'h0;
  // ==========================================
  // counts
  localparam int FSM_SAMPLE_DIV = 64;
  localparam int FSM_SUT_PERIODS = 1024;
  // ==========================================
  // external clock modes, driven by configuration
  typedef enum logic [2:0] {
    FSM_MODE_SLOW_XTAL = 3'h0,
    FSM_MODE_XTAL = 3'h1,
    FSM_MODE_FAST_XTAL = 3'h2,
    FSM_MODE_EXT_IN = 3'h3,
    FSM_MODE_SEC_OSC = 3'h4,
    FSM_MODE_RES_CAP = 3'h5
  } fsm_mode_t;
  // ==========================================
  // control states
  typedef enum logic [4:0] {
    FSM_S_SUT = 5'b00001,
    FSM_S_EXT = 5'b00010,
    FSM_S_INT = 5'b00100,
    FSM_S_FAIL = 5'b01000,
    FSM_S_SLEEP = 5'b10000
  } fsm_state_t;
endpackage

// ===== src/fsm_clock_fail_monitor.sv
// clock fail monitor: failure detector, start-up timer, fallback clock select
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - failure detection only after the start-up timer has expired
// - monitor works only when the monitor enable fuse is set
// - monitoring covers all external clock modes
// - sample clock is the low-frequency internal oscillator divided by 64
// - detector latch set on every falling edge of the external clock
// - detector latch cleared on every rising edge of the sample clock that brings no external falling edge
// - failure when a full sample half period passes with no external low
// - on failure switch to internal source and set the failure flag
// - flag raises an interrupt only with the irq enable bit set
// - stay internal until firmware restarts external and switch succeeds
// - fallback frequency comes from the four-bit internal frequency select
// - fail-safe cleared by reset, sleep, or a clock source select change
// - source select change restarts timer; run internal while it counts
// - on timer expiry switch to external, or to internal when css_reg bit 1 is set; fail-safe already cleared by the select change
// - a still failing external clock sets the flag again
// - start-up timer runs after wake-up and after every reset
// - external input and resistor-capacitor modes skip the start-up timer
// - monitor enable forces two-speed start-up on the internal clock
// - crystal modes count 1024 oscillator periods before use
module fsm_clock_fail_monitor
  import fsm_pkg::*;
#(
  parameter int SAMPLE_DIV = FSM_SAMPLE_DIV,
  parameter int SUT_PERIODS = FSM_SUT_PERIODS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic EXT_CLK,
  input wire logic LF_OSC,
  input wire logic MONITOR_ENABLE_FUSE,
  input wire logic [2:0] CLK_MODE,
  input wire logic SLEEP_EXEC,
  input wire logic WAKE_UP,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic SEL_EXT_CLK,
  output logic SEL_INT_CLK,
  output logic [3:0] INT_FREQ_SEL,
  output logic OSC_FAIL_IRQ,
  output logic FAILSAFE_ACTIVE,
  output logic CORE_HOLD
);
  localparam int HALF_DIV = SAMPLE_DIV / 2;
  localparam int DIV_W = $clog2(HALF_DIV);
  localparam int SUT_W = $clog2(SUT_PERIODS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);
  localparam logic [SUT_W-1:0] SUT_LOAD = SUT_W'(SUT_PERIODS);

  // ==========================================
  // pin synchronisers
  // external clock must stay below half the system rate to be seen
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_d_reg;
  logic lf_s1_reg;
  logic lf_s2_reg;
  logic lf_d_reg;

  // low reset value can only fake a rising edge, never a falling one
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg <= 1'b0;
    end else begin
      ext_s1_reg <= EXT_CLK;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lf_s1_reg <= 1'b0;
      lf_s2_reg <= 1'b0;
      lf_d_reg <= 1'b0;
    end else begin
      lf_s1_reg <= LF_OSC;
      lf_s2_reg <= lf_s1_reg;
      lf_d_reg <= lf_s2_reg;
    end
  end

  wire ext_fall = ext_d_reg & ~ext_s2_reg;
  wire lf_rise = lf_s2_reg & ~lf_d_reg;

  // ==========================================
  // sample clock divider
  logic [DIV_W-1:0] div_reg;
  logic sample_reg;
  wire div_wrap = lf_rise & (div_reg == DIV_LAST);
  wire [DIV_W-1:0] div_next = div_wrap ? '0 : (lf_rise ? div_reg + 1'b1 : div_reg);
  wire sample_rise = div_wrap & ~sample_reg;
  wire sample_fall = div_wrap & sample_reg;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= sample_reg ^ div_wrap;
    end
  end

  // ==========================================
  // fail detector latch
  logic seen_low_reg;
  // set by external falling edge, wins over clear
  wire seen_low_next = ext_fall | (seen_low_reg & ~sample_rise);
  // whole high half of the sample clock without an external low
  // decided entirely in the system clock domain
  wire fail_seen = sample_fall & ~seen_low_reg & ~ext_fall;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      seen_low_reg <= 1'b0;
    end else begin
      seen_low_reg <= seen_low_next;
    end
  end

  // ==========================================
  // register bus decode
  logic [3:0] ifs_reg;
  logic [1:0] css_reg;
  logic flag_reg;
  logic irq_en_reg;
  wire wr_ctl = WR & (ADDR == FSM_OFS_OSC_CONTROL);
  wire wr_flag = WR & (ADDR == FSM_OFS_FLAG2);
  wire wr_en = WR & (ADDR == FSM_OFS_ENABLE2);
  wire [1:0] css_wdata = WDATA[FSM_CSS_LSB +: 2];
  // only a real change of the select bits counts
  wire css_change = wr_ctl & (css_wdata != css_reg);
  // fallback frequency held ready before any failure
  wire [3:0] ifs_next = wr_ctl ? WDATA[FSM_IFS_LSB +: 4] : ifs_reg;
  wire [1:0] css_next = wr_ctl ? css_wdata : css_reg;
  wire irq_en_next = wr_en ? WDATA[FSM_IRQEN_BIT] : irq_en_reg;

  // ==========================================
  // mode decode
  wire mode_no_sut = (CLK_MODE == FSM_MODE_EXT_IN) | (CLK_MODE == FSM_MODE_RES_CAP);
  wire want_internal = css_reg[1];

  // ==========================================
  // start-up timer
  fsm_state_t state_reg;
  fsm_state_t state_next;
  logic [SUT_W-1:0] sut_reg;
  // loaded on reset and on wake-up
  // reloaded on a source select change
  // no count in external input or resistor-capacitor mode
  // crystal modes wait 1024 oscillator periods
  wire sut_restart = css_change | (state_reg == FSM_S_SLEEP);
  wire sut_done = (sut_reg == '0);
  wire [SUT_W-1:0] sut_load = mode_no_sut ? '0 : SUT_LOAD;
  wire [SUT_W-1:0] sut_next = sut_restart ? sut_load :
                              ((ext_fall & ~sut_done) ? sut_reg - 1'b1 : sut_reg);
  logic sut_init_reg;

  // ==========================================
  // control state machine
  // no detection without the fuse
  // detection only once running on external, timer expired
  // all external modes share one detector
  wire monitor_on = MONITOR_ENABLE_FUSE & (state_reg == FSM_S_EXT);
  wire fail_hit = monitor_on & fail_seen;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FSM_S_SUT: begin
        // timer expiry moves to external, or to internal when css_reg bit 1 is set
        if (sut_done & ~sut_restart & ~sut_init_reg) begin
          state_next = want_internal ? FSM_S_INT : FSM_S_EXT;
        end
      end
      FSM_S_EXT: begin
        // failure moves to the internal source
        // a still dead clock fails here again
        if (fail_hit) begin
          state_next = FSM_S_FAIL;
        end else if (css_change) begin
          state_next = FSM_S_SUT;
        end
      end
      FSM_S_INT: begin
        if (css_change) begin
          state_next = FSM_S_SUT;
        end
      end
      FSM_S_FAIL: begin
        // held internal until firmware changes source select
        if (css_change) begin
          state_next = FSM_S_SUT;
        end
      end
      FSM_S_SLEEP: begin
        if (WAKE_UP) begin
          state_next = FSM_S_SUT;
        end
      end
    endcase
    // sleep clears fail-safe from any state
    if (SLEEP_EXEC) begin
      state_next = FSM_S_SLEEP;
    end
  end

  // set wins over a software write of zero
  wire flag_next = fail_hit | (flag_reg & ~(wr_flag & ~WDATA[FSM_FLAG_BIT]));

  // ==========================================
  // control registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= FSM_S_SUT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sut_reg <= '0;
    end else begin
      sut_reg <= sut_init_reg ? sut_load : sut_next;
    end
  end

  // first clock after reset loads the timer for the strapped mode
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sut_init_reg <= 1'b1;
    end else begin
      sut_init_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ifs_reg <= FSM_IFS_RESET;
    end else begin
      ifs_reg <= ifs_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      css_reg <= FSM_CSS_RESET;
    end else begin
      css_reg <= css_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_en_reg <= 1'b0;
    end else begin
      irq_en_reg <= irq_en_next;
    end
  end

  // ==========================================
  // glitch-free clock select
  // internal clock runs code while the timer counts
  // break before make: one cycle with neither source
  // next state, so the external select drops on the same edge as the flag
  wire want_ext = (state_next == FSM_S_EXT);
  wire sel_ext_next = want_ext & ~SEL_INT_CLK;
  wire sel_int_next = ~want_ext & ~SEL_EXT_CLK & (state_next != FSM_S_SLEEP);
  // without the fuse the core waits out the timer instead
  wire hold_next = ~MONITOR_ENABLE_FUSE & (state_next == FSM_S_SUT);
  wire irq_next = flag_next & irq_en_next;
  wire failsafe_next = (state_next == FSM_S_FAIL);

  // ==========================================
  // read mux
  // status shows timer done and the clock in use
  wire [7:0] status_word = {3'h0, sample_reg, SEL_INT_CLK, FAILSAFE_ACTIVE,
                            SEL_EXT_CLK, sut_done};
  wire [7:0] ctl_word = {1'b0, ifs_reg, 1'b0, css_reg};
  wire [7:0] flag_word = {flag_reg, 7'h00};
  wire [7:0] en_word = {irq_en_reg, 7'h00};
  wire [7:0] rd_word = (ADDR == FSM_OFS_OSC_CONTROL) ? ctl_word :
                       (ADDR == FSM_OFS_OSC_STATUS) ? status_word :
                       (ADDR == FSM_OFS_FLAG2) ? flag_word :
                       (ADDR == FSM_OFS_ENABLE2) ? en_word : 8'h00;
  wire [7:0] rdata_next = RD ? rd_word : 8'h00;

  // ==========================================
  // output registers
  // zero outside the read slot, so a stale value never shows
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SEL_EXT_CLK <= 1'b0;
    end else begin
      SEL_EXT_CLK <= sel_ext_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SEL_INT_CLK <= 1'b1;
    end else begin
      SEL_INT_CLK <= sel_int_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      INT_FREQ_SEL <= FSM_IFS_RESET;
    end else begin
      INT_FREQ_SEL <= ifs_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      OSC_FAIL_IRQ <= 1'b0;
    end else begin
      OSC_FAIL_IRQ <= irq_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FAILSAFE_ACTIVE <= 1'b0;
    end else begin
      FAILSAFE_ACTIVE <= failsafe_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      CORE_HOLD <= 1'b0;
    end else begin
      CORE_HOLD <= hold_next;
    end
  end
endmodule
`default_nettype wire

// ===== sim/fsm_ext_osc.sv
// external oscillator model for the clock fail monitor bench
`timescale 1ns/1ps
`default_nettype none
// ====
// oscillator
module fsm_ext_osc #(
  parameter int HALF_NS = 500
) (
  input wire logic run,
  output logic osc_out
);
  // a dead source parks high, so no falling edge ever sets the latch
  initial begin
    osc_out = 1'b1;
    forever begin
      #(HALF_NS);
      osc_out = run ? ~osc_out : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/fsm_clock_fail_monitor_monitor.sv
// assertion checker for the clock fail monitor ports
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module fsm_cfm_checker
  import fsm_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MONITOR_ENABLE_FUSE,
  input wire logic SLEEP_EXEC,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SEL_EXT_CLK,
  input wire logic SEL_INT_CLK,
  input wire logic [3:0] INT_FREQ_SEL,
  input wire logic OSC_FAIL_IRQ,
  input wire logic FAILSAFE_ACTIVE,
  input wire logic CORE_HOLD
);
  logic [3:0] freq_reg;
  wire ctl_wr = WR && ADDR == FSM_OFS_OSC_CONTROL;
  wire en_wr = WR && ADDR == FSM_OFS_ENABLE2;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      freq_reg <= FSM_IFS_RESET;
    end else if (ctl_wr) begin
      freq_reg <= WDATA[6:3];
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_SEL_EXCL: assert property (!(SEL_EXT_CLK && SEL_INT_CLK))
    else $error("both selects high");
  AST_FAIL_SW: assert property ($rose(FAILSAFE_ACTIVE) |-> !SEL_EXT_CLK ##1 SEL_INT_CLK)
    else $error("no switch on failure");
  AST_FAIL_EXT: assert property ($rose(FAILSAFE_ACTIVE) |-> $past(SEL_EXT_CLK))
    else $error("failure seen off external");
  AST_STAY_INT: assert property (FAILSAFE_ACTIVE |-> !SEL_EXT_CLK)
    else $error("external during fail-safe");
  AST_FS_HOLD: assert property (
    FAILSAFE_ACTIVE && !SLEEP_EXEC && !ctl_wr |=> FAILSAFE_ACTIVE)
    else $error("fail-safe dropped");
  AST_SLEEP_CLR: assert property (SLEEP_EXEC |-> ##[1:2] !FAILSAFE_ACTIVE)
    else $error("sleep kept fail-safe");
  AST_FUSE_OFF: assert property (!MONITOR_ENABLE_FUSE |-> !FAILSAFE_ACTIVE)
    else $error("fail-safe with fuse off");
  AST_TWO_SPEED: assert property (MONITOR_ENABLE_FUSE |-> !CORE_HOLD)
    else $error("core held with fuse on");
  AST_IRQ_CAUSE: assert property (
    $rose(OSC_FAIL_IRQ) |-> FAILSAFE_ACTIVE || $past(en_wr) || $past(en_wr, 2))
    else $error("irq without cause");
  AST_FREQ: assert property (ctl_wr |-> ##2 INT_FREQ_SEL == freq_reg)
    else $error("frequency select not copied");
  AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside slot");
endmodule
bind fsm_clock_fail_monitor fsm_cfm_checker fsm_cfm_checker_inst (
  .CLK_SYS, .RST_N, .MONITOR_ENABLE_FUSE, .SLEEP_EXEC, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .SEL_EXT_CLK, .SEL_INT_CLK, .INT_FREQ_SEL, .OSC_FAIL_IRQ, .FAILSAFE_ACTIVE, .CORE_HOLD);
`default_nettype wire

// ===== sim/fsm_clock_fail_monitor_bench.sv
// self-checking bench for the clock fail monitor
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module fsm_clock_fail_monitor_bench;
  import fsm_pkg::*;
  logic clk_sys = 0, rst_n = 0, run = 0, lf_osc = 0, fuse = 1;
  logic sleep_exec = 0, wake_up = 0, wr = 0, rd = 0;
  logic [2:0] mode = 3'h1;
  logic [3:0] addr = 4'h0, ifs;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic ext_clk, sel_ext, sel_int, irq, fs, hold;
  int miscompares = 0, tests_run = 0, cycles = 0, n;
  fsm_ext_osc fsm_ext_osc_inst (.run(run), .osc_out(ext_clk));
  // short counts keep each start-up and detection within a few hundred cycles
  fsm_clock_fail_monitor #(.SAMPLE_DIV(4), .SUT_PERIODS(8)) fsm_clock_fail_monitor_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .EXT_CLK(ext_clk), .LF_OSC(lf_osc),
    .MONITOR_ENABLE_FUSE(fuse), .CLK_MODE(mode), .SLEEP_EXEC(sleep_exec), .WAKE_UP(wake_up),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SEL_EXT_CLK(sel_ext),
    .SEL_INT_CLK(sel_int), .INT_FREQ_SEL(ifs), .OSC_FAIL_IRQ(irq), .FAILSAFE_ACTIVE(fs),
    .CORE_HOLD(hold));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    forever #800 lf_osc = ~lf_osc;
  end
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask
  task automatic pulse(input bit wake);
    @(posedge clk_sys);
    if (wake) wake_up <= 1'b1; else sleep_exec <= 1'b1;
    @(posedge clk_sys);
    wake_up <= 1'b0;
    sleep_exec <= 1'b0;
  endtask
  task automatic boot(input logic [2:0] m, input logic f);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    mode <= m;
    fuse <= f;
    run = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  // cycles until fail-safe (want_fs) or external select shows, capped at lim
  task automatic await(input bit want_fs, input int lim);
    n = 0;
    while ((want_fs ? fs : sel_ext) !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic t_reset();
    boot(FSM_MODE_XTAL, 1'b1);
    @(negedge clk_sys);
    chk(8'({sel_ext, sel_int, fs, irq}), 8'h04);
    chk(8'(ifs), 8'(FSM_IFS_RESET));
    rreg(FSM_OFS_OSC_CONTROL);
    chk(d, 8'(FSM_IFS_RESET) << FSM_IFS_LSB);
    rreg(4'hF);
    chk(d, 8'h00);
  endtask
  task automatic t_modes();
    // last mode booted is a crystal one, so recovery below runs the timer
    for (int m = 5; m >= 0; m--) begin
      boot(3'(m), 1'b1);
      await(1'b0, 400);
      chk(8'(n < 400), 8'h01);
      chk(8'(3'(m) inside {FSM_MODE_EXT_IN, FSM_MODE_RES_CAP} ? n < 30 : n >= 70), 8'h01);
      rreg(FSM_OFS_OSC_STATUS);
      chk(d & 8'h0F, 8'h03);
      wreg(FSM_OFS_ENABLE2, 8'h80);
      run = 1'b0;
      await(1'b1, 300);
      chk(8'({n < 300, sel_ext, irq}), 8'h05);
      rreg(FSM_OFS_FLAG2);
      chk(d & 8'h80, 8'h80);
    end
  endtask
  task automatic t_recover();
    wreg(FSM_OFS_FLAG2, 8'h00);
    @(negedge clk_sys);
    chk(8'({irq, sel_int}), 8'h01);
    pulse(1'b0);
    @(negedge clk_sys);
    chk(8'({sel_ext, sel_int, fs}), 8'h00);
    run = 1'b1;
    pulse(1'b1);
    await(1'b0, 400);
    chk(8'({n < 400, n >= 60}), 8'h03);
    run = 1'b0;
    await(1'b1, 300);
    chk(8'(n < 300), 8'h01);
    wreg(FSM_OFS_FLAG2, 8'h00);
    rreg(FSM_OFS_FLAG2);
    chk(d, 8'h00);
    run = 1'b1;
    wreg(FSM_OFS_OSC_CONTROL, 8'h39);
    repeat (2) @(negedge clk_sys);
    chk(8'({fs, sel_ext, sel_int}), 8'h01);
    await(1'b0, 400);
    chk(8'({n < 400, n >= 60, fs}), 8'h06);
    wreg(FSM_OFS_OSC_CONTROL, 8'h02);
    repeat (2) @(negedge clk_sys);
    chk(8'(ifs), 8'h00);
  endtask
  task automatic t_fuse();
    boot(FSM_MODE_XTAL, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(8'(hold), 8'h01);
    await(1'b0, 400);
    run = 1'b0;
    repeat (200) @(negedge clk_sys);
    chk(8'({sel_ext, fs}), 8'h02);
  endtask
  initial begin
    t_reset();
    t_modes();
    t_recover();
    t_fuse();
    conclude();
  end
endmodule
`default_nettype wire
